// ### hdl/rf_control_config_regs.sv
// Radio front-end control registers on a classic Wishbone slave.
// Assumes a 40 MHz clock; supply comparator input is asynchronous.
//
// The Wishbone register port was chosen for this implementation.
`timescale 1ns/1ps
`include "rf_ctrl_defs.svh"

module rf_control_config_regs #(
    parameter int FAST_WAKE_CYC = `WAKE_FAST_CYC,
    parameter int SLOW_WAKE_CYC = `WAKE_SLOW_CYC
) (
    // Clock and reset
    input  wire logic        CORE_CLK_I,
    input  wire logic        SRST_I,
    // Wishbone slave
    input  wire logic        CYC_I,
    input  wire logic        STB_I,
    input  wire logic        WE_I,
    input  wire logic [13:0] ADR_I,
    input  wire logic [3:0]  SEL_I,
    input  wire logic [31:0] DAT_I,
    output logic [31:0]      DAT_O,
    output logic             ACK_O,
    // Supply comparator and sleep wake
    input  wire logic        SUPPLY_BELOW_I,
    input  wire logic        WAKE_START_I,
    output logic             WAKE_READY_O,
    // Analog controls
    output logic [1:0]       TX_POWER_COARSE_O,
    output logic [2:0]       TX_POWER_FINE_O,
    output logic             SYNTH_LOOP_ON_O,
    output logic             TX_FILTER_CTRL_O,
    output logic             FAST_WAKE_RECOVERY_O,
    output logic             SUPPLY_MONITOR_ON_O,
    output logic [3:0]       SUPPLY_TRIP_LEVEL_O,
    output logic             SUPPLY_LOW_FLAG_O
);

    // ----------------------------------------
    // Storage
    // ----------------------------------------
    logic [7:0] tx_power_control;
    logic [7:0] battery_threshold_control;
    logic [7:0] filter_recovery_battery_control;
    logic [7:0] synth_pll_control;
    logic       below_meta;
    logic       below_sync;
    rf_ctrl_pkg::radio_ctrl_s ctrl;
    rf_ctrl_pkg::bus_state_e  bus_state;

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    function automatic logic hit(input logic [13:0] adr,
                                 input logic [11:0] idx);
        hit = (adr[13:2] == idx) && (adr[1:0] == 2'b00);
    endfunction

    wire req      = CYC_I && STB_I && (bus_state == rf_ctrl_pkg::BUS_IDLE);
    wire wr_lane  = req && WE_I && SEL_I[0];
    wire hit_pll  = hit(ADR_I, `IDX_SYNTH_PLL);
    wire hit_pwr  = hit(ADR_I, `IDX_TX_POWER);
    wire hit_trip = hit(ADR_I, `IDX_BATT_THRESH);
    wire hit_filt = hit(ADR_I, `IDX_FILT_RECOV);
    wire hit_stat = hit(ADR_I, `IDX_RX_STATUS);
    // Reserved bits are masked so they always read zero
    wire [7:0] wdat = DAT_I[7:0];

    // Status register holds only the supply low flag
    wire [7:0] status_byte = 8'(SUPPLY_LOW_FLAG_O) << `POS_SUPPLY_LOW;

    wire [7:0] rd_byte =
        hit_pll  ? synth_pll_control :
        hit_pwr  ? tx_power_control :
        hit_trip ? battery_threshold_control :
        hit_filt ? filter_recovery_battery_control :
        hit_stat ? status_byte : 8'h00;

    // ----------------------------------------
    // Field extraction
    // ----------------------------------------
    always_comb begin
        ctrl.tx_power_coarse = tx_power_control
            [`POS_PWR_COARSE_HI:`POS_PWR_COARSE_LO];
        ctrl.tx_power_fine = tx_power_control
            [`POS_PWR_FINE_HI:`POS_PWR_FINE_LO];
        ctrl.synth_loop_on = synth_pll_control[`POS_PLL_ON];
        ctrl.tx_filter_ctrl =
            filter_recovery_battery_control[`POS_TX_FILTER];
        ctrl.fast_wake_recovery =
            filter_recovery_battery_control[`POS_FAST_WAKE];
        ctrl.supply_monitor_on =
            filter_recovery_battery_control[`POS_MON_ON];
        ctrl.supply_trip_level = battery_threshold_control
            [`POS_TRIP_HI:`POS_TRIP_LO];
    end

    // ----------------------------------------
    // Registers and bus answer
    // ----------------------------------------
    // Single-cycle ack; one idle cycle follows so ack drops
    always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I) begin
            synth_pll_control               <= `RST_REG;
            tx_power_control                <= `RST_REG;
            battery_threshold_control       <= `RST_REG;
            filter_recovery_battery_control <= `RST_REG;
            bus_state                       <= rf_ctrl_pkg::BUS_IDLE;
            ACK_O                           <= 1'b0;
            DAT_O                           <= 32'h0;
        end else begin
            ACK_O     <= req;
            bus_state <= req ? rf_ctrl_pkg::BUS_ACK : rf_ctrl_pkg::BUS_IDLE;
            if (req && !WE_I)
                DAT_O <= {24'h0, rd_byte};
            if (wr_lane && hit_pll)
                synth_pll_control <= wdat & `MASK_SYNTH_PLL;
            if (wr_lane && hit_pwr)
                tx_power_control <= wdat & `MASK_TX_POWER;
            if (wr_lane && hit_trip)
                battery_threshold_control <= wdat & `MASK_BATT_THRESH;
            if (wr_lane && hit_filt)
                filter_recovery_battery_control <= wdat & `MASK_FILT_RECOV;
        end
    end

    // ----------------------------------------
    // Supply monitor
    // ----------------------------------------
    // Comparator is analog and asynchronous: two flops first
    always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I) begin
            below_meta        <= 1'b0;
            below_sync        <= 1'b0;
            SUPPLY_LOW_FLAG_O <= 1'b0;
        end else begin
            below_meta        <= SUPPLY_BELOW_I;
            below_sync        <= below_meta;
            SUPPLY_LOW_FLAG_O <= ctrl.supply_monitor_on && below_sync;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I) begin
            TX_POWER_COARSE_O    <= 2'h0;
            TX_POWER_FINE_O      <= 3'h0;
            SYNTH_LOOP_ON_O      <= 1'b0;
            TX_FILTER_CTRL_O     <= 1'b0;
            FAST_WAKE_RECOVERY_O <= 1'b0;
            SUPPLY_MONITOR_ON_O  <= 1'b0;
            SUPPLY_TRIP_LEVEL_O  <= 4'h0;
        end else begin
            TX_POWER_COARSE_O    <= ctrl.tx_power_coarse;
            TX_POWER_FINE_O      <= ctrl.tx_power_fine;
            SYNTH_LOOP_ON_O      <= ctrl.synth_loop_on;
            TX_FILTER_CTRL_O     <= ctrl.tx_filter_ctrl;
            FAST_WAKE_RECOVERY_O <= ctrl.fast_wake_recovery;
            SUPPLY_MONITOR_ON_O  <= ctrl.supply_monitor_on;
            SUPPLY_TRIP_LEVEL_O  <= ctrl.supply_trip_level;
        end
    end

    // Wake timer; WAKE_START_I comes from same-clock sleep logic
    wake_timer #(
        .FAST_CYC (FAST_WAKE_CYC),
        .SLOW_CYC (SLOW_WAKE_CYC)
    ) u_wake (
        .clk_i   (CORE_CLK_I),
        .srst_i  (SRST_I),
        .fast_i  (ctrl.fast_wake_recovery),
        .start_i (WAKE_START_I),
        .ready_o (WAKE_READY_O)
    );

endmodule

// ### hdl/wake_timer.sv
// Wake-from-sleep recovery timer for the 40 MHz clock.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`include "rf_ctrl_defs.svh"

module wake_timer #(
    parameter int FAST_CYC = `WAKE_FAST_CYC,
    parameter int SLOW_CYC = `WAKE_SLOW_CYC
) (
    input  wire logic clk_i,
    input  wire logic srst_i,
    input  wire logic fast_i,
    input  wire logic start_i,
    output logic      ready_o
);
    logic [17:0] count;
    wire  [17:0] limit = fast_i ? 18'(FAST_CYC - 1) : 18'(SLOW_CYC - 1);

    // Limit is one below the count: ready rises FAST_CYC or SLOW_CYC cycles after start
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            count   <= 18'h0;
            ready_o <= 1'b0;
        end else if (start_i) begin
            count   <= 18'h0;
            ready_o <= 1'b0;
        end else if (!ready_o) begin
            count   <= count + 18'h1;
            ready_o <= (count >= limit);
        end
    end
endmodule

// ### include/rf_ctrl_defs.svh
// Offsets, field positions, reset values and timing counts of the
// radio front-end control bank. Included by bare name.
`ifndef RF_CTRL_DEFS_SVH
`define RF_CTRL_DEFS_SVH

// Register indices (byte address = 4 * index)
`define IDX_SYNTH_PLL       12'h202
`define IDX_TX_POWER        12'h203
`define IDX_BATT_THRESH     12'h205
`define IDX_FILT_RECOV      12'h206
`define IDX_RX_STATUS       12'h030

// Field positions
`define POS_PLL_ON          7
`define POS_PWR_COARSE_HI   7
`define POS_PWR_COARSE_LO   6
`define POS_PWR_FINE_HI     5
`define POS_PWR_FINE_LO     3
`define POS_TRIP_HI         7
`define POS_TRIP_LO         4
`define POS_TX_FILTER       7
`define POS_FAST_WAKE       4
`define POS_MON_ON          3
`define POS_SUPPLY_LOW      5

// Writable masks; reserved bits hold zero
`define MASK_SYNTH_PLL      8'h80
`define MASK_TX_POWER       8'hf8
`define MASK_BATT_THRESH    8'hf0
`define MASK_FILT_RECOV     8'h98

`define RST_REG             8'h00

// Wake recovery bounds in microseconds at a 40 MHz clock
`define CLK_MHZ             40
`define WAKE_FAST_US        1000
`define WAKE_SLOW_US        3000
`define WAKE_FAST_CYC       (`WAKE_FAST_US * `CLK_MHZ)
`define WAKE_SLOW_CYC       (`WAKE_SLOW_US * `CLK_MHZ)

`endif

// ### include/rf_ctrl_pkg.sv
// Types shared by the radio control bank.
// Assumes rf_ctrl_defs.svh is compiled alongside.
package rf_ctrl_pkg;

    typedef struct packed {
        logic [1:0] tx_power_coarse;
        logic [2:0] tx_power_fine;
        logic       synth_loop_on;
        logic       tx_filter_ctrl;
        logic       fast_wake_recovery;
        logic       supply_monitor_on;
        logic [3:0] supply_trip_level;
    } radio_ctrl_s;

    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_ACK
    } bus_state_e;

endpackage

// ### tb/rf_regs_props.sv
// Port assertions for the radio control register bank.
// Bound to every instance; sees the top-level ports only.
`timescale 1ns/1ps
module rf_regs_props (
    input wire logic        CORE_CLK_I,
    input wire logic        SRST_I,
    input wire logic        CYC_I,
    input wire logic        STB_I,
    input wire logic        WE_I,
    input wire logic [13:0] ADR_I,
    input wire logic [3:0]  SEL_I,
    input wire logic [31:0] DAT_I,
    input wire logic [31:0] DAT_O,
    input wire logic        ACK_O,
    input wire logic        SUPPLY_BELOW_I,
    input wire logic [1:0]  TX_POWER_COARSE_O,
    input wire logic [2:0]  TX_POWER_FINE_O,
    input wire logic        SYNTH_LOOP_ON_O,
    input wire logic        SUPPLY_MONITOR_ON_O,
    input wire logic        SUPPLY_LOW_FLAG_O
);
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (SRST_I);
    wire        wr_ack = ACK_O && CYC_I && STB_I && WE_I && SEL_I[0];
    logic [4:0] pwr;
    logic       pll;
    // Last accepted field values, for the output checks
    always_ff @(posedge CORE_CLK_I) begin
        if (wr_ack && ADR_I == 14'h80c) pwr <= DAT_I[7:3];
        if (wr_ack && ADR_I == 14'h808) pll <= DAT_I[7];
    end
    a_ack_pulse:
        assert property (ACK_O |=> !ACK_O) else $error("ack too long");
    a_ack_answer:
        assert property ($rose(STB_I) && CYC_I |=> ACK_O)
            else $error("no ack one cycle after request");
    a_reset_clear:
        assert property ($fell(SRST_I) |-> !ACK_O && !SYNTH_LOOP_ON_O
            && !SUPPLY_MONITOR_ON_O) else $error("not clear after reset");
    a_power_follow:
        assert property (wr_ack && ADR_I == 14'h80c |-> ##[1:2]
            {TX_POWER_COARSE_O, TX_POWER_FINE_O} == pwr)
            else $error("power outputs differ from write");
    a_pll_follow:
        assert property (wr_ack && ADR_I == 14'h808 |-> ##[1:2]
            SYNTH_LOOP_ON_O == pll) else $error("pll output wrong");
    a_status_bits:
        assert property (ACK_O && !WE_I && ADR_I == 14'h0c0 |->
            DAT_O[31:6] == 0 && DAT_O[4:0] == 0)
            else $error("status read has stray bits");
    a_flag_off:
        assert property (!SUPPLY_MONITOR_ON_O && !$past(SUPPLY_MONITOR_ON_O)
            |-> !SUPPLY_LOW_FLAG_O) else $error("flag set while off");
    a_flag_on:
        assert property ((SUPPLY_BELOW_I && SUPPLY_MONITOR_ON_O)[*5] |->
            SUPPLY_LOW_FLAG_O) else $error("flag missing");
    a_flag_low:
        assert property ((!SUPPLY_BELOW_I)[*5] |-> !SUPPLY_LOW_FLAG_O)
            else $error("flag stuck high");
    cover property (SUPPLY_LOW_FLAG_O);
    cover property (wr_ack && ADR_I == 14'h80c);
    cover property (ACK_O && !WE_I && ADR_I == 14'h0c0);
endmodule

bind rf_control_config_regs rf_regs_props i_rf_regs_props (.*);

// ### tb/testbench.sv
// Self-checking bench for the radio control register bank.
// Drives Wishbone and the comparator; wake counts cut to 10/30.
`timescale 1ns/1ps
`include "rf_ctrl_defs.svh"
module testbench;
    logic        clk = 0, srst = 1, cyc = 0, stb = 0, we = 0;
    logic        below = 0, wstart = 0, ack, wready, pll, filt, fastw;
    logic        mon, low;
    logic [13:0] adr = 0;
    logic [3:0]  sel = 0, trip;
    logic [31:0] wdat = 0, rdat, got;
    logic [1:0]  coarse;
    logic [2:0]  fine;
    int          mismatches = 0, checks_done = 0;
    localparam logic [13:0] A_PLL = {`IDX_SYNTH_PLL, 2'b00};
    localparam logic [13:0] A_PWR = {`IDX_TX_POWER, 2'b00};
    localparam logic [13:0] A_TH = {`IDX_BATT_THRESH, 2'b00};
    localparam logic [13:0] A_FR = {`IDX_FILT_RECOV, 2'b00};
    localparam logic [13:0] A_ST = {`IDX_RX_STATUS, 2'b00};
    localparam logic [13:0] A_ALL [5] = '{A_PLL, A_PWR, A_TH, A_FR, A_ST};
    rf_control_config_regs #(.FAST_WAKE_CYC(10), .SLOW_WAKE_CYC(30))
    i_rf_control_config_regs (
        .CORE_CLK_I(clk), .SRST_I(srst), .CYC_I(cyc), .STB_I(stb),
        .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(wdat), .DAT_O(rdat),
        .ACK_O(ack), .SUPPLY_BELOW_I(below), .WAKE_START_I(wstart),
        .WAKE_READY_O(wready), .TX_POWER_COARSE_O(coarse),
        .TX_POWER_FINE_O(fine), .SYNTH_LOOP_ON_O(pll),
        .TX_FILTER_CTRL_O(filt), .FAST_WAKE_RECOVERY_O(fastw),
        .SUPPLY_MONITOR_ON_O(mon), .SUPPLY_TRIP_LEVEL_O(trip),
        .SUPPLY_LOW_FLAG_O(low));
    initial begin
        forever #12.5 clk = ~clk;
    end
    task results;
        if (mismatches == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %0t got %h exp %h", $time, g, e);
        end
    endtask
    // Whole classic cycle; ack may take any time up to the bound
    task bus(input logic w, input logic [13:0] a, input logic [7:0] d);
        int n;
        @(posedge clk);
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= a;
        sel <= 4'hf;
        wdat <= {24'h0, d};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        got = rdat;
        cyc <= 0;
        stb <= 0;
        if (ack !== 1'b1) begin
            chk(0, 1);
            results;
        end
    endtask
    task t_reset;
        for (int i = 0; i < 5; i++) begin
            bus(0, A_ALL[i], 0);
            chk(got, 0);
        end
        chk({pll, filt, mon, fastw, low}, 0);
    endtask
    task t_fields;
        bus(1, A_PLL, 8'h80);
        for (int v = 0; v < 32; v++) begin
            bus(1, A_PWR, {v[4:0], 3'b000});
            bus(0, A_PWR, 0);
            chk(got, {v[4:0], 3'b000});
            chk({coarse, fine}, v[4:0]);
        end
        for (int v = 0; v < 16; v++) begin
            bus(1, A_TH, {v[3:0], 4'h0});
            bus(0, A_TH, 0);
            chk(got, {v[3:0], 4'h0});
            chk(trip, v[3:0]);
        end
        bus(1, A_PLL, 8'h80);
        bus(1, A_FR, 8'h98);
        bus(1, 14'h3fc, 8'hff);
        bus(0, 14'h3fc, 0);
        chk(got, 0);
        bus(0, A_FR, 0);
        chk(got, 8'h98);
        chk({pll, filt, fastw, mon}, 4'hf);
        bus(1, A_PLL, 0);
        bus(0, A_PLL, 0);
        chk({got[7], pll}, 0);
    endtask
    task t_supply;
        bus(1, A_FR, 8'h90);
        below <= 1;
        repeat (6) @(posedge clk);
        chk(low, 0);
        bus(0, A_ST, 0);
        chk(got, 0);
        bus(1, A_FR, 8'h08);
        repeat (6) @(posedge clk);
        chk(low, 1);
        bus(0, A_ST, 0);
        chk(got, 32'h20);
        below <= 0;
        repeat (6) @(posedge clk);
        chk(low, 0);
    endtask
    task t_wake(input logic f, input int lim);
        int n;
        bus(1, A_FR, {3'b000, f, 4'h8});
        @(posedge clk);
        wstart <= 1;
        @(posedge clk);
        wstart <= 0;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wready !== 1'b1 && n < 100);
        if (wready !== 1'b1) begin
            chk(0, 1);
            results;
        end else begin
            chk(n > lim - 3 && n < lim + 3, 1);
        end
    endtask
    initial begin
        repeat (10) @(posedge clk);
        srst <= 0;
        t_reset;
        t_fields;
        t_supply;
        t_wake(0, 30);
        t_wake(1, 10);
        bus(1, A_PLL, 8'h80);
        srst <= 1;
        repeat (3) @(posedge clk);
        srst <= 0;
        t_reset;
        results;
    end
endmodule
